// ---- harness_pkg.sv ----
/*
  constants, state codes and register map of the traffic test harness
  control shell.
  assumes one clock domain (core_clk) shared with the lane protocol core.
*/
// What this block does
// - restart request launches generator and monitor sequences
// - restart honoured only while both sides idle
// - tx-only: far aligned input lets generator start
// - tx lock indicator, driven only in tx-only
// - complete indicator after all packets sent
// - fifo error indicator on overflow or underflow
// - generator active indicator; restart ignored meanwhile
// - alignment indicator once receiver reports aligned
// - all user inputs and outputs pass three flops
// - duplex: both paths, loopback, generator and monitor
// - tx-only: transmitter and generator only
// - rx-only: receiver and monitor only
// - flow select: 1 packet flow, 0 burst
// - only duplex counts as supported
// - tx-only generator waits for far aligned input
// - packet count even, 2 to 65534
// - packet flow channel 0..255 then wraps
package harness_pkg;

  // ==========================================================
  // register map (byte addresses, one word each)
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_PKT_CNT  = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h14;
  localparam logic [7:0] ADDR_TX_SENT  = 8'h18;
  localparam logic [7:0] ADDR_RX_SEEN  = 8'h1c;

  localparam logic [15:0] PKT_CNT_RST  = 16'h0010;
  localparam logic [15:0] PKT_CNT_MIN  = 16'h0002;

  // ==========================================================
  // arrangements
  typedef enum logic [1:0] {
    ARR_DUPLEX  = 2'h0,
    ARR_TX_ONLY = 2'h1,
    ARR_RX_ONLY = 2'h2
  } arrangement_t;

  localparam logic       FLOW_PACKET = 1'b1;
  localparam logic [7:0] CH_FIRST    = 8'h00;
  localparam logic [7:0] BURST_CH_A  = 8'h05;
  localparam logic [7:0] BURST_CH_B  = 8'h0a;

  // ==========================================================
  // state codes
  typedef enum logic [7:0] {
    G_IDLE  = 8'h01,
    G_LOCK  = 8'h02,
    G_ALIGN = 8'h04,
    G_EN    = 8'h08,
    G_TX0   = 8'h10,
    G_TX1   = 8'h20,
    G_HOLD  = 8'h40,
    G_DONE  = 8'h80
  } gen_state_t;

  typedef enum logic [5:0] {
    M_IDLE  = 6'h01,
    M_LOCK  = 6'h02,
    M_ALIGN = 6'h04,
    M_EN    = 6'h08,
    M_RX    = 6'h10,
    M_DONE  = 6'h20
  } mon_state_t;

  // ==========================================================
  // interrupt bits, user input and indicator vector positions
  localparam int IRQ_W        = 4;
  localparam int IRQ_GEN_DONE = 0;
  localparam int IRQ_GEN_FIFO = 1;
  localparam int IRQ_MON_DONE = 2;
  localparam int IRQ_MON_FAIL = 3;

  localparam int IN_W = 4;
  localparam int IN_SYSRST = 0;
  localparam int IN_RESTART = 1;
  localparam int IN_FAR_ALIGN = 2;
  localparam int IN_FLOW = 3;

  localparam int IND_W = 9;

  // force a legal packet count: even, never below two
  function automatic logic [15:0] legal_count(input logic [15:0] req);
    logic [15:0] even;
    even = {req[15:1], 1'b0};
    legal_count = (even < PKT_CNT_MIN) ? PKT_CNT_MIN : even;
  endfunction : legal_count

endpackage : harness_pkg

// ---- sync3.sv ----
/*
  three-stage register chain for user pins and indicators.
  assumes the destination runs on clk; source may be asynchronous.
*/
`timescale 1ns/100ps
module sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;

  // =========================================================
  // chain
  // only the next stage reads s1_ff, so metastability stays put
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      q     <= '0;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      q     <= s2_ff;
    end
  end

endmodule : sync3

// ---- pkt_mon_seq.sv ----
/*
  packet monitor sequencer: waits for lock and alignment, enables the
  receiver, counts packet ends and records any mismatch report.
  assumes the core flags rx_pkt_error on a mismatching beat.
*/
`timescale 1ns/100ps
module pkt_mon_seq
  import harness_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        clr,
  input  wire logic        start,
  input  wire logic [15:0] count,
  input  wire logic        locked,
  input  wire logic        aligned,
  input  wire logic        pkt_valid,
  input  wire logic        pkt_eop,
  input  wire logic        pkt_error,
  output logic             busy,
  output logic             done,
  output logic             failed,
  output logic             enable,
  output logic      [15:0] seen
);

  mon_state_t state_ff;
  mon_state_t nxt_state;

  // =========================================================
  // next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      M_IDLE:  if (start) nxt_state = M_LOCK;
      M_LOCK:  if (locked) nxt_state = M_ALIGN;
      M_ALIGN: if (aligned) nxt_state = M_EN;
      M_EN:    nxt_state = M_RX;
      M_RX: begin
        if (pkt_valid && pkt_eop && (seen + 16'h0001 == count))
          nxt_state = M_DONE;
      end
      M_DONE:  nxt_state = M_IDLE;
      default: nxt_state = M_IDLE;
    endcase
  end

  // =========================================================
  // state and outputs; clr is the synchronised system reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= M_IDLE;
      busy     <= 1'b0;
      done     <= 1'b0;
      failed   <= 1'b0;
      enable   <= 1'b0;
      seen     <= 16'h0000;
    end else if (clr) begin
      state_ff <= M_IDLE;
      busy     <= 1'b0;
      done     <= 1'b0;
      failed   <= 1'b0;
      enable   <= 1'b0;
      seen     <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      if (start && state_ff == M_IDLE) begin
        busy   <= 1'b1;
        done   <= 1'b0;
        failed <= 1'b0;
        seen   <= 16'h0000;
      end
      if (state_ff == M_EN)
        enable <= 1'b1;
      if (state_ff == M_RX && pkt_valid) begin
        if (pkt_eop)
          seen <= seen + 16'h0001;
        if (pkt_error)
          failed <= 1'b1;
      end
      if (state_ff == M_DONE) begin
        done   <= 1'b1;
        busy   <= 1'b0;
        enable <= 1'b0;
      end
    end
  end

endmodule : pkt_mon_seq

// ---- traffic_harness.sv ----
/*
  control and status shell of the traffic test harness: user pins,
  packet generator sequencer, monitor instance, avalon-mm registers
  and one level interrupt.
  assumes the protocol core shares core_clk; user pins are async.
*/
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module traffic_harness (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  input  wire logic        sys_reset_in,
  input  wire logic        traffic_restart_request,
  input  wire logic        far_receiver_aligned_in,
  input  wire logic        flow_style_select,
  input  wire logic        serdes_locked,
  input  wire logic        rx_core_aligned,
  input  wire logic        tx_core_ready,
  input  wire logic        tx_fifo_overflow,
  input  wire logic        tx_fifo_underflow,
  input  wire logic        rx_pkt_valid,
  input  wire logic        rx_pkt_eop,
  input  wire logic        rx_pkt_error,
  output logic             core_reset,
  output logic             serdes_loopback,
  output logic             tx_enable,
  output logic             tx_valid,
  output logic             tx_sop,
  output logic             tx_eop,
  output logic      [7:0]  tx_channel,
  output logic             rx_enable,
  output logic             tx_serdes_lock_indicator,
  output logic             rx_serdes_lock_indicator,
  output logic             rx_lanes_aligned_indicator,
  output logic             gen_complete_indicator,
  output logic             gen_fifo_error_indicator,
  output logic             gen_active_indicator,
  output logic             mon_active_indicator,
  output logic             mon_complete_indicator,
  output logic             mon_fail_indicator
);
  import harness_pkg::*;

  // ==========================================================
  // declarations
  logic [IN_W-1:0]  pin_q;
  logic [IND_W-1:0] ind_d;
  logic             sysrst_s;
  logic             restart_s;
  logic             far_align_s;
  logic             flow_s;
  logic             restart_prev_ff;
  logic             restart_go;
  arrangement_t     arr_ff;
  logic [15:0]      pkt_cnt_ff;
  logic             gen_on;
  logic             mon_on;
  gen_state_t       gst_ff;
  gen_state_t       nxt_gst;
  gen_state_t       hold_ret_ff;
  logic [15:0]      sent_ff;
  logic             gen_busy_ff;
  logic             gen_done_ff;
  logic             gen_fifo_ff;
  logic             lock_seen_ff;
  logic             align_seen_ff;
  logic             aligned_ok;
  logic             last_pkt;
  logic             mon_busy;
  logic             mon_done;
  logic             mon_failed;
  logic             mon_en;
  logic [15:0]      mon_seen;
  logic             mon_done_prev_ff;
  logic             mon_fail_prev_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_en_ff;
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_clr;
  logic             bus_req;
  logic             bus_go;

  // ==========================================================
  // user pins: three stages in
  sync3 #(.W(IN_W)) u_pin_sync (
    .clk  (core_clk),
    .rstn (rstn),
    .d    ({flow_style_select, far_receiver_aligned_in,
            traffic_restart_request, sys_reset_in}),
    .q    (pin_q)
  );

  assign sysrst_s    = pin_q[IN_SYSRST];
  assign restart_s   = pin_q[IN_RESTART];
  assign far_align_s = pin_q[IN_FAR_ALIGN];
  assign flow_s      = pin_q[IN_FLOW];

  // restart edge, honoured only when both sequencers are idle and
  // the lagging indicators have dropped too
  assign restart_go = restart_s && !restart_prev_ff
                      && !gen_busy_ff && !mon_busy
                      && !gen_active_indicator
                      && !mon_active_indicator;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      restart_prev_ff <= 1'b0;
    else
      restart_prev_ff <= restart_s;
  end

  // ==========================================================
  // arrangement decode
  assign gen_on = (arr_ff != ARR_RX_ONLY);
  assign mon_on = (arr_ff != ARR_TX_ONLY);

  // no local alignment exists in tx-only, the far party tells us
  assign aligned_ok = (arr_ff == ARR_TX_ONLY) ? far_align_s
                                              : rx_core_aligned;
  assign last_pkt   = (sent_ff + 16'h0001 == pkt_cnt_ff);

  // ==========================================================
  // core control: reset follows the switch, paths per arrangement
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      core_reset      <= 1'b1;
      serdes_loopback <= 1'b0;
      rx_enable       <= 1'b0;
    end else begin
      core_reset      <= sysrst_s;
      serdes_loopback <= (arr_ff == ARR_DUPLEX);
      rx_enable       <= mon_en && mon_on;
    end
  end

  // ==========================================================
  // generator next state
  always_comb begin
    nxt_gst = gst_ff;
    case (gst_ff)
      G_IDLE:  if (restart_go && gen_on) nxt_gst = G_LOCK;
      G_LOCK:  if (serdes_locked) nxt_gst = G_ALIGN;
      G_ALIGN: if (aligned_ok) nxt_gst = G_EN;
      G_EN:    nxt_gst = G_TX0;
      G_TX0:   nxt_gst = !tx_core_ready ? G_HOLD : G_TX1;
      G_TX1: begin
        if (!tx_core_ready)
          nxt_gst = G_HOLD;
        else if (last_pkt)
          nxt_gst = G_DONE;
        else
          nxt_gst = G_TX0;
      end
      G_HOLD:  if (tx_core_ready) nxt_gst = hold_ret_ff;
      G_DONE:  nxt_gst = G_IDLE;
      default: nxt_gst = G_IDLE;
    endcase
  end

  // ==========================================================
  // generator state and beat outputs; a packet is two beats
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gst_ff      <= G_IDLE;
      hold_ret_ff <= G_TX0;
      tx_enable   <= 1'b0;
      tx_valid    <= 1'b0;
      tx_sop      <= 1'b0;
      tx_eop      <= 1'b0;
      tx_channel  <= CH_FIRST;
      sent_ff     <= 16'h0000;
    end else if (sysrst_s) begin
      gst_ff      <= G_IDLE;
      hold_ret_ff <= G_TX0;
      tx_enable   <= 1'b0;
      tx_valid    <= 1'b0;
      tx_sop      <= 1'b0;
      tx_eop      <= 1'b0;
      tx_channel  <= CH_FIRST;
      sent_ff     <= 16'h0000;
    end else begin
      gst_ff   <= nxt_gst;
      tx_valid <= 1'b0;
      tx_sop   <= 1'b0;
      tx_eop   <= 1'b0;
      if (gst_ff == G_IDLE && nxt_gst == G_LOCK) begin
        sent_ff    <= 16'h0000;
        tx_channel <= flow_s == FLOW_PACKET ? CH_FIRST : BURST_CH_A;
      end
      if (gst_ff == G_EN)
        tx_enable <= 1'b1;
      if ((gst_ff == G_TX0 || gst_ff == G_TX1) && !tx_core_ready)
        hold_ret_ff <= gst_ff;
      if (gst_ff == G_TX0 && tx_core_ready) begin
        tx_valid <= 1'b1;
        tx_sop   <= 1'b1;
      end
      if (gst_ff == G_TX1 && tx_core_ready) begin
        tx_valid <= 1'b1;
        tx_eop   <= 1'b1;
        sent_ff  <= sent_ff + 16'h0001;
      end
      // channel steps after each packet end; 8 bits wrap 255 -> 0
      if (gst_ff == G_TX1 && tx_core_ready) begin
        if (flow_s == FLOW_PACKET)
          tx_channel <= tx_channel + 8'h01;
        else
          tx_channel <= (tx_channel == BURST_CH_A) ? BURST_CH_B
                                                   : BURST_CH_A;
      end
      if (gst_ff == G_DONE)
        tx_enable <= 1'b0;
    end
  end

  // ==========================================================
  // generator flags; busy drops in the done state, the others hold until the next accepted restart
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gen_busy_ff   <= 1'b0;
      gen_done_ff   <= 1'b0;
      gen_fifo_ff   <= 1'b0;
      lock_seen_ff  <= 1'b0;
      align_seen_ff <= 1'b0;
    end else if (sysrst_s) begin
      gen_busy_ff   <= 1'b0;
      gen_done_ff   <= 1'b0;
      gen_fifo_ff   <= 1'b0;
      lock_seen_ff  <= 1'b0;
      align_seen_ff <= 1'b0;
    end else begin
      if (gst_ff == G_IDLE && nxt_gst == G_LOCK)
        gen_busy_ff <= 1'b1;
      else if (gst_ff == G_DONE)
        gen_busy_ff <= 1'b0;
      if (gst_ff == G_DONE)
        gen_done_ff <= 1'b1;
      else if (restart_go)
        gen_done_ff <= 1'b0;
      // a fresh error wins over the restart clear
      if (gen_on && (tx_fifo_overflow || tx_fifo_underflow))
        gen_fifo_ff <= 1'b1;
      else if (restart_go)
        gen_fifo_ff <= 1'b0;
      if (serdes_locked)
        lock_seen_ff <= 1'b1;
      else if (restart_go)
        lock_seen_ff <= 1'b0;
      if (rx_core_aligned && mon_on)
        align_seen_ff <= 1'b1;
      else if (restart_go)
        align_seen_ff <= 1'b0;
    end
  end

  // ==========================================================
  // monitor sequencer
  pkt_mon_seq u_mon (
    .clk       (core_clk),
    .rstn      (rstn),
    .clr       (sysrst_s),
    .start     (restart_go && mon_on),
    .count     (pkt_cnt_ff),
    .locked    (serdes_locked),
    .aligned   (rx_core_aligned),
    .pkt_valid (rx_pkt_valid),
    .pkt_eop   (rx_pkt_eop),
    .pkt_error (rx_pkt_error),
    .busy      (mon_busy),
    .done      (mon_done),
    .failed    (mon_failed),
    .enable    (mon_en),
    .seen      (mon_seen)
  );

  // ==========================================================
  // indicators: three stages out
  assign ind_d = {mon_failed && mon_done,
                  mon_done,
                  mon_busy,
                  gen_busy_ff,
                  gen_fifo_ff,
                  gen_done_ff,
                  align_seen_ff,
                  lock_seen_ff && mon_on,
                  lock_seen_ff && (arr_ff == ARR_TX_ONLY)};

  sync3 #(.W(IND_W)) u_ind_sync (
    .clk  (core_clk),
    .rstn (rstn),
    .d    (ind_d),
    .q    ({mon_fail_indicator, mon_complete_indicator,
            mon_active_indicator, gen_active_indicator,
            gen_fifo_error_indicator, gen_complete_indicator,
            rx_lanes_aligned_indicator, rx_serdes_lock_indicator,
            tx_serdes_lock_indicator})
  );

  // ==========================================================
  // monitor interrupt events are rising edges of its sticky flags; generator events are the done state and raw fifo errors
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mon_done_prev_ff <= 1'b0;
      mon_fail_prev_ff <= 1'b0;
    end else begin
      mon_done_prev_ff <= mon_done;
      mon_fail_prev_ff <= mon_failed;
    end
  end

  assign irq_evt[IRQ_GEN_DONE] = (gst_ff == G_DONE);
  assign irq_evt[IRQ_GEN_FIFO] = gen_on
                                 && (tx_fifo_overflow || tx_fifo_underflow);
  assign irq_evt[IRQ_MON_DONE] = mon_done && !mon_done_prev_ff;
  assign irq_evt[IRQ_MON_FAIL] = mon_failed && !mon_fail_prev_ff;

  // ==========================================================
  // avalon-mm slave: one wait state, then read data and write land
  assign bus_req = avs_read || avs_write;
  assign bus_go  = bus_req && !avs_waitrequest;
  assign irq_clr = (bus_go && avs_write && avs_address == ADDR_IRQ_CLR)
                   ? avs_writedata[IRQ_W-1:0] : '0;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !(bus_req && avs_waitrequest);
  end

  // writable registers; packet count is forced legal on write
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      arr_ff     <= ARR_DUPLEX;
      pkt_cnt_ff <= PKT_CNT_RST;
      irq_en_ff  <= '0;
    end else if (bus_go && avs_write) begin
      case (avs_address)
        ADDR_CTRL:    arr_ff <= arrangement_t'(avs_writedata[1:0]);
        ADDR_PKT_CNT: pkt_cnt_ff <= legal_count(avs_writedata[15:0]);
        ADDR_IRQ_EN:  irq_en_ff <= avs_writedata[IRQ_W-1:0];
        default:      ;
      endcase
    end
  end

  // sticky status: a set in the clear cycle survives
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_ff <= '0;
      irq         <= 1'b0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_evt;
      irq         <= |(irq_stat_ff & irq_en_ff);
    end
  end

  // read data is staged during the wait cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      case (avs_address)
        ADDR_CTRL:     avs_readdata <= {30'h0, arr_ff};
        ADDR_PKT_CNT:  avs_readdata <= {16'h0, pkt_cnt_ff};
        // top bit flags an arrangement outside duplex
        ADDR_STATUS:   avs_readdata <= {(arr_ff != ARR_DUPLEX),
                                        9'h0, gst_ff, 6'h00,
                                        mon_failed, mon_done, mon_busy,
                                        gen_fifo_ff, gen_done_ff,
                                        gen_busy_ff, align_seen_ff,
                                        lock_seen_ff};
        ADDR_IRQ_STAT: avs_readdata <= {28'h0, irq_stat_ff};
        ADDR_IRQ_EN:   avs_readdata <= {28'h0, irq_en_ff};
        ADDR_TX_SENT:  avs_readdata <= {16'h0, sent_ff};
        ADDR_RX_SEEN:  avs_readdata <= {16'h0, mon_seen};
        default:       avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : traffic_harness

// ---- harness_checker.sv ----
/* checker of port timing for the harness shell.
   assumes a bind from the bench; one clock, async rstn. */
`timescale 1ns/100ps
module harness_checker (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic sys_reset_in,
  input wire logic core_reset,
  input wire logic tx_valid,
  input wire logic tx_sop,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic tx_serdes_lock_indicator,
  input wire logic gen_complete_indicator,
  input wire logic gen_active_indicator,
  input wire logic mon_active_indicator
);
  // ========================================
  // all checks on core_clk
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("no bus answer");
  AST_BUS_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low twice");
  AST_SYS_RESET: assert property (sys_reset_in [*5] |-> core_reset)
    else $error("core not reset");
  AST_RESET_STOPS: assert property ($rose(core_reset) |-> ##1
    !tx_enable && !rx_enable) else $error("path left on");
  AST_SOP_BEAT: assert property (tx_sop |-> tx_valid && tx_enable)
    else $error("sop outside beat");
  AST_RX_NOT_TX:
    assert property (rx_enable |-> !tx_serdes_lock_indicator)
    else $error("rx on in tx-only");
  AST_DONE_IDLE: assert property ($rose(gen_complete_indicator)
    |-> !gen_active_indicator) else $error("done while busy");
  // done may only drop by a taken restart or a system reset
  AST_DONE_KEEP: assert property ($fell(gen_complete_indicator)
    |-> gen_active_indicator || mon_active_indicator || core_reset)
    else $error("done lost");
endmodule : harness_checker

// ---- core_model.sv ----
/* far side model: protocol core, serdes and loopback.
   assumes the bench drives inject to corrupt beats. */
`timescale 1ns/100ps
module core_model (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic core_reset,
  input  wire logic serdes_loopback,
  input  wire logic tx_valid,
  input  wire logic tx_eop,
  input  wire logic rx_enable,
  input  wire logic inject,
  output logic      serdes_locked,
  output logic      rx_core_aligned,
  output logic      rx_pkt_valid,
  output logic      rx_pkt_eop,
  output logic      rx_pkt_error
);
  logic [2:0] lock_cnt_ff;
  // ========================================
  // lock four cycles after core reset ends
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lock_cnt_ff <= 3'h0;
    end else if (core_reset) begin
      lock_cnt_ff <= 3'h0;
    end else if (!lock_cnt_ff[2]) begin
      lock_cnt_ff <= lock_cnt_ff + 3'h1;
    end
  end
  assign serdes_locked   = lock_cnt_ff[2];
  assign rx_core_aligned = serdes_locked; // never aligned before lock
  // loopback mirrors tx; else a far sender sends one-beat packets
  assign rx_pkt_valid = serdes_loopback ? tx_valid : rx_enable;
  assign rx_pkt_eop   = serdes_loopback ? tx_eop : rx_enable;
  assign rx_pkt_error = inject && rx_pkt_valid; // bad only on demand
endmodule : core_model

// ---- traffic_harness_tb.sv ----
/* bench for the harness shell: bus tasks, scenarios, verdict.
   assumes core_model at the far side and the checker bound below. */
`timescale 1ns/100ps
module traffic_harness_tb;
  import harness_pkg::*;
  // ========================================
  // stimulus, outputs and score
  logic core_clk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00, tx_channel;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic sys_reset_in = 1'b0, traffic_restart_request = 1'b0, inject = 1'b0;
  logic far_receiver_aligned_in = 1'b0, flow_style_select = 1'b1;
  logic tx_core_ready = 1'b1, tx_fifo_overflow = 1'b0, tx_fifo_underflow = 1'b0;
  logic avs_waitrequest, irq, core_reset, serdes_loopback, tx_enable, tx_valid;
  logic tx_sop, tx_eop, rx_enable, serdes_locked, rx_core_aligned, rx_pkt_valid;
  logic rx_pkt_eop, rx_pkt_error, tx_serdes_lock_indicator;
  logic rx_serdes_lock_indicator, rx_lanes_aligned_indicator;
  logic gen_complete_indicator, gen_fifo_error_indicator, gen_active_indicator;
  logic mon_active_indicator, mon_complete_indicator, mon_fail_indicator;
  int miscompares = 0, compares = 0;
  logic [7:0] chq[$];
  traffic_harness dut (.*);
  core_model far_end (.*);
  // 125 MHz core clock
  always #4 core_clk = ~core_clk;
  // channel of each packet start
  always @(posedge core_clk) if (tx_valid && tx_sop) chq.push_back(tx_channel);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one bus cycle; a read compares against d
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (!wr) chk(avs_readdata, d);
  endtask : bus
  task automatic wait_lvl(ref logic s, input logic v);
    int n;
    for (n = 0; n < 3000 && s !== v; n++) @(posedge core_clk);
    chk(s, v);
  endtask : wait_lvl
  // pin held 4 cycles so the synchroniser sees it
  task automatic go();
    traffic_restart_request <= 1'b1;
    repeat (4) @(posedge core_clk);
    traffic_restart_request <= 1'b0;
    @(posedge core_clk);
  endtask : go

  task automatic t_regs();
    bus(1'b0, ADDR_PKT_CNT, {16'h0, PKT_CNT_RST});
    bus(1'b1, ADDR_PKT_CNT, 32'h5);
    bus(1'b0, ADDR_PKT_CNT, 32'h4);
    bus(1'b1, ADDR_PKT_CNT, 32'h1);
    bus(1'b0, ADDR_PKT_CNT, 32'h2);
    bus(1'b0, 8'h40, 32'h0);
    bus(1'b1, ADDR_PKT_CNT, 32'h4);
  endtask : t_regs
  task automatic t_duplex();
    bus(1'b1, ADDR_IRQ_EN, 32'hf);
    go();
    wait_lvl(gen_active_indicator, 1'b1);
    chk(mon_active_indicator, 1'b1);
    chk(serdes_loopback, 1'b1);
    tx_core_ready <= 1'b0;
    tx_fifo_underflow <= 1'b1;
    go();
    tx_core_ready <= 1'b1;
    tx_fifo_underflow <= 1'b0;
    wait_lvl(gen_complete_indicator, 1'b1);
    wait_lvl(mon_complete_indicator, 1'b1);
    chk(mon_fail_indicator, 1'b0);
    chk(gen_fifo_error_indicator, 1'b1);
    chk(rx_lanes_aligned_indicator, 1'b1);
    chk(rx_serdes_lock_indicator, 1'b1);
    chk({chq[0], chq[1], chq[3]}, {CH_FIRST, 8'h01, 8'h03});
    chk(chq.size(), 4);
    bus(1'b0, ADDR_IRQ_STAT, 32'h7);
    chk(irq, 1'b1);
    bus(1'b1, ADDR_IRQ_EN, 32'h0);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b0);
    bus(1'b1, ADDR_IRQ_CLR, 32'hf);
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
  endtask : t_duplex
  // core alignment is high here, yet only the far pin may start
  task automatic t_txonly();
    bus(1'b1, ADDR_CTRL, {30'h0, ARR_TX_ONLY});
    flow_style_select <= 1'b0;
    chq.delete();
    go();
    wait_lvl(gen_active_indicator, 1'b1);
    repeat (40) @(posedge core_clk);
    chk(tx_enable, 1'b0);
    chk(tx_serdes_lock_indicator, 1'b1);
    chk(mon_active_indicator, 1'b0);
    far_receiver_aligned_in <= 1'b1;
    wait_lvl(gen_complete_indicator, 1'b1);
    chk({chq[0], chq[1]}, {BURST_CH_A, BURST_CH_B});
    far_receiver_aligned_in <= 1'b0;
  endtask : t_txonly
  task automatic t_rxonly();
    bus(1'b1, ADDR_CTRL, {30'h0, ARR_RX_ONLY});
    inject <= 1'b1;
    go();
    wait_lvl(mon_active_indicator, 1'b1);
    chk(gen_active_indicator, 1'b0);
    wait_lvl(mon_complete_indicator, 1'b1);
    chk(mon_fail_indicator, 1'b1);
    inject <= 1'b0;
  endtask : t_rxonly
  task automatic t_sysrst();
    sys_reset_in <= 1'b1;
    repeat (12) @(posedge core_clk);
    chk(core_reset, 1'b1);
    chk(mon_fail_indicator, 1'b0);
    sys_reset_in <= 1'b0;
  endtask : t_sysrst

  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  // main sequence after a 3-cycle reset
  initial begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    t_regs();
    t_duplex();
    t_txonly();
    t_rxonly();
    t_sysrst();
    print_verdict();
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    print_verdict();
  end
endmodule : traffic_harness_tb

bind traffic_harness harness_checker u_chk (.*);
